// *** include/fault_history_pkg.sv ***
// constants, layouts and types shared by the fault history memory
// Notes on behaviour
// - severity codes: 0 warning, 1 and 2 quick stop, 3 fatal acknowledgeable, 4 fatal not.
// - writing 1 to the clear command erases every stored entry.
// - clear command reads 0 once erasure is done; master polls for 0.
// - reading the error number copies the whole current entry into a holding buffer.
// - each error number read of a stored entry advances the read pointer to the following entry.
// - writing 1 to the rewind command moves the read pointer to the oldest entry.
// - entries hold motor current, unsigned 16 bits, 10 mA steps.
// - entries hold bus voltage, unsigned 16 bits, 100 mV steps.
// - entries hold error time in seconds, saturated at 536870911.
// - a 32-bit read-only power-on cycle count saturates at 4294967295.
// - entries hold a 16-bit supplementary code chosen per error number.
// - entries hold signed 16-bit speed, power stage and device temperatures.
// - entries hold the unsigned 16-bit count of enable cycles since supply on.
// - entries hold seconds since power stage enable, unsigned 16 bits.
package fault_history_pkg;

  // parameter addresses as printed
  localparam logic [15:0] ADDR_POWER_ON_CYCLE_COUNT    = 16'h3b04;
  localparam logic [15:0] ADDR_CLEAR_HISTORY_COMMAND   = 16'h3b08;
  localparam logic [15:0] ADDR_REWIND_READ_POINTER     = 16'h3b0a;
  localparam logic [15:0] ADDR_ENTRY_ERROR_NUMBER      = 16'h3c02;
  localparam logic [15:0] ADDR_ENTRY_SEVERITY          = 16'h3c04;
  localparam logic [15:0] ADDR_ENTRY_TIMESTAMP         = 16'h3c06;
  localparam logic [15:0] ADDR_ENTRY_EXTRA_INFO        = 16'h3c08;
  localparam logic [15:0] ADDR_ENTRY_ENABLE_CYCLES     = 16'h3c0a;
  localparam logic [15:0] ADDR_ENTRY_TIME_AFTER_ENABLE = 16'h3c0c;
  localparam logic [15:0] ADDR_ENTRY_BUS_VOLTAGE       = 16'h3c0e;
  localparam logic [15:0] ADDR_ENTRY_MOTOR_SPEED       = 16'h3c10;
  localparam logic [15:0] ADDR_ENTRY_MOTOR_CURRENT     = 16'h3c12;
  localparam logic [15:0] ADDR_ENTRY_POWER_STAGE_TEMP  = 16'h3c14;
  localparam logic [15:0] ADDR_ENTRY_DEVICE_TEMP       = 16'h3c16;

  // command value and limits
  localparam logic [15:0] CMD_EXECUTE        = 16'h0001;
  localparam logic [31:0] TIMESTAMP_MAX      = 32'h1fff_ffff;
  localparam logic [31:0] POWER_ON_MAX       = 32'hffff_ffff;
  localparam logic [15:0] COUNT16_MAX        = 16'hffff;

  // reset values
  localparam logic [31:0] POWER_ON_RESET     = 32'h0000_0000;
  localparam logic [15:0] ENABLE_COUNT_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_TIME_RESET  = 16'h0000;
  localparam logic [31:0] RDATA_RESET        = 32'h0000_0000;

  typedef enum logic [2:0] {
    SEV_WARNING      = 3'h0,
    SEV_QUICK_STOP_A = 3'h1,
    SEV_QUICK_STOP_B = 3'h2,
    SEV_FATAL_ACK    = 3'h3,
    SEV_FATAL_NOACK  = 3'h4
  } severity_type;

  typedef enum logic [1:0] {
    CLR_IDLE = 2'b01,
    CLR_RUN  = 2'b10
  } clr_state_type;

  // what the error detection hands over with each event
  typedef struct packed {
    logic        [15:0] err_num;
    logic        [2:0]  severity;
    logic        [15:0] extra_info;
    logic        [15:0] motor_current;
    logic        [15:0] bus_voltage;
    logic signed [15:0] motor_speed;
    logic signed [15:0] power_stage_temp;
    logic signed [15:0] device_temp;
  } fault_event_type;

  // one stored entry
  typedef struct packed {
    logic        [15:0] err_num;
    severity_type       severity;
    logic        [31:0] timestamp;
    logic        [15:0] extra_info;
    logic        [15:0] enable_cycles;
    logic        [15:0] time_after_enable;
    logic        [15:0] bus_voltage;
    logic signed [15:0] motor_speed;
    logic        [15:0] motor_current;
    logic signed [15:0] power_stage_temp;
    logic signed [15:0] device_temp;
  } entry_type;

endpackage : fault_history_pkg

// *** design/fault_history_memory.sv ***
// fault history memory with parameter-address read and command access
`timescale 1ns/1ps
`default_nettype none

module fault_history_memory #(
  parameter int ENTRY_DEPTH = 16
) (
  input  wire logic                              CLK_IN,        // 250 MHz clock
  input  wire logic                              RST_IN,        // sync reset, active high
  input  wire logic                              POWER_ON_IN,   // one pulse per power-on cycle
  input  wire logic                              ENABLE_IN,     // power stage enabled level
  input  wire logic                              SEC_TICK_IN,   // one pulse per second
  input  wire logic [31:0]                       OP_SECONDS_IN, // operating-hours counter in s
  input  wire logic                              LOG_VALID_IN,  // pulse: log the event below
  input  wire fault_history_pkg::fault_event_type LOG_EVENT_IN, // event content
  input  wire logic [15:0]                       PAR_ADDR_IN,   // parameter address
  input  wire logic                              PAR_RD_IN,     // read strobe
  input  wire logic                              PAR_WR_IN,     // write strobe
  input  wire logic [15:0]                       PAR_WDATA_IN,  // write data
  output logic      [31:0]                       PAR_RDATA_OUT, // read data
  output logic                                   PAR_ACK_OUT,   // read data valid pulse
  output logic                                   CLEAR_BUSY_OUT // erasure in progress
);
  import fault_history_pkg::*;

  localparam int IW = (ENTRY_DEPTH > 1) ? $clog2(ENTRY_DEPTH) : 1;
  localparam int CW = $clog2(ENTRY_DEPTH + 1);
  localparam logic [IW-1:0] LAST_SLOT = IW'(ENTRY_DEPTH - 1);
  localparam logic [CW-1:0] FULL_FILL = CW'(ENTRY_DEPTH);

  generate
    if (ENTRY_DEPTH < 2)
    begin : g_depth_check
      $error("ENTRY_DEPTH must be at least 2");
    end
  endgenerate

  entry_type     mem_q [ENTRY_DEPTH];
  entry_type     hold_q;
  entry_type     cur_entry;
  entry_type     new_entry;
  entry_type     view_entry;
  clr_state_type clr_state_q;
  logic [IW-1:0] clr_idx_q;
  logic [IW-1:0] wr_ptr_q;
  logic [IW-1:0] cur_slot;
  logic [CW-1:0] fill_q;
  logic [CW-1:0] rd_idx_q;
  logic [CW-1:0] rd_idx_d;
  logic [31:0]   power_on_q;
  logic [15:0]   enable_cycles_q;
  logic [15:0]   enable_time_q;
  logic          enable_prev_q;
  logic          enable_rise;
  logic          rd_num;
  logic          wr_clr;
  logic          wr_rew;
  logic          log_take;
  logic          cur_valid;
  logic          clearing;

  // maps the addressed parameter to its read value
  function automatic logic [31:0] read_value(
    input logic [15:0] addr,
    input entry_type   e,
    input logic        busy,
    input logic [31:0] power_on
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (addr)
      ADDR_POWER_ON_CYCLE_COUNT:    v = power_on;
      ADDR_CLEAR_HISTORY_COMMAND:   v = 32'(busy);
      ADDR_REWIND_READ_POINTER:     v = 32'h0000_0000;
      ADDR_ENTRY_ERROR_NUMBER:      v = {16'h0000, e.err_num};
      ADDR_ENTRY_SEVERITY:          v = 32'(e.severity);
      ADDR_ENTRY_TIMESTAMP:         v = e.timestamp;
      ADDR_ENTRY_EXTRA_INFO:        v = {16'h0000, e.extra_info};
      ADDR_ENTRY_ENABLE_CYCLES:     v = {16'h0000, e.enable_cycles};
      ADDR_ENTRY_TIME_AFTER_ENABLE: v = {16'h0000, e.time_after_enable};
      ADDR_ENTRY_BUS_VOLTAGE:       v = {16'h0000, e.bus_voltage};
      ADDR_ENTRY_MOTOR_SPEED:       v = {16'h0000, e.motor_speed};
      ADDR_ENTRY_MOTOR_CURRENT:     v = {16'h0000, e.motor_current};
      ADDR_ENTRY_POWER_STAGE_TEMP:  v = {16'h0000, e.power_stage_temp};
      ADDR_ENTRY_DEVICE_TEMP:       v = {16'h0000, e.device_temp};
      default:                      v = 32'h0000_0000;
    endcase
    return v;
  endfunction : read_value

  // request decode
  assign clearing    = (clr_state_q == CLR_RUN);
  assign rd_num      = PAR_RD_IN && (PAR_ADDR_IN == ADDR_ENTRY_ERROR_NUMBER);
  assign wr_clr      = PAR_WR_IN && (PAR_ADDR_IN == ADDR_CLEAR_HISTORY_COMMAND) && (PAR_WDATA_IN == CMD_EXECUTE);
  assign wr_rew      = PAR_WR_IN && (PAR_ADDR_IN == ADDR_REWIND_READ_POINTER) && (PAR_WDATA_IN == CMD_EXECUTE);
  assign log_take    = LOG_VALID_IN && !clearing && !wr_clr;
  assign enable_rise = ENABLE_IN && !enable_prev_q;
  assign cur_valid   = (rd_idx_q < fill_q);

  // slot of the entry under the read pointer, counted from the oldest
  always_comb
  begin
    int unsigned slot;
    slot     = (int'(wr_ptr_q) + ENTRY_DEPTH - int'(fill_q) + int'(rd_idx_q)) % ENTRY_DEPTH;
    cur_slot = IW'(slot);
  end

  assign cur_entry  = cur_valid ? mem_q[cur_slot] : '0;
  assign view_entry = rd_num ? cur_entry : hold_q;

  // assemble the entry for an incoming event
  always_comb
  begin
    new_entry = '0;
    new_entry.err_num          = LOG_EVENT_IN.err_num;
    if (LOG_EVENT_IN.severity > SEV_FATAL_NOACK)
    begin
      new_entry.severity = SEV_FATAL_NOACK;
    end
    else
    begin
      new_entry.severity = severity_type'(LOG_EVENT_IN.severity);
    end
    new_entry.timestamp        = (OP_SECONDS_IN > TIMESTAMP_MAX) ? TIMESTAMP_MAX : OP_SECONDS_IN;
    new_entry.extra_info       = LOG_EVENT_IN.extra_info;
    new_entry.enable_cycles    = enable_cycles_q;
    new_entry.time_after_enable = enable_time_q;
    new_entry.bus_voltage      = LOG_EVENT_IN.bus_voltage;
    new_entry.motor_speed      = LOG_EVENT_IN.motor_speed;
    new_entry.motor_current    = LOG_EVENT_IN.motor_current;
    new_entry.power_stage_temp = LOG_EVENT_IN.power_stage_temp;
    new_entry.device_temp      = LOG_EVENT_IN.device_temp;
  end

  // entry storage: erasure walk or event write
  always_ff @(posedge CLK_IN)
  begin
    if (clearing)
    begin
      mem_q[clr_idx_q] <= '0;
    end
    else if (log_take)
    begin
      mem_q[wr_ptr_q] <= new_entry;
    end
  end

  // erasure sequencer
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      clr_state_q <= CLR_IDLE;
      clr_idx_q   <= '0;
    end
    else
    begin
      unique case (clr_state_q)
        CLR_IDLE:
        begin
          clr_idx_q <= '0;
          if (wr_clr)
          begin
            clr_state_q <= CLR_RUN;
          end
        end
        CLR_RUN:
        begin
          clr_idx_q <= clr_idx_q + 1'b1;
          if (clr_idx_q == LAST_SLOT)
          begin
            clr_state_q <= CLR_IDLE;
          end
        end
        default:
        begin
          clr_state_q <= CLR_IDLE;
        end
      endcase
    end
  end

  // write pointer and fill level; the oldest entry is overwritten when full
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      wr_ptr_q <= '0;
      fill_q   <= '0;
    end
    else if (wr_clr && !clearing)
    begin
      wr_ptr_q <= '0;
      fill_q   <= '0;
    end
    else if (log_take)
    begin
      wr_ptr_q <= (wr_ptr_q == LAST_SLOT) ? '0 : wr_ptr_q + 1'b1;
      if (fill_q != FULL_FILL)
      begin
        fill_q <= fill_q + 1'b1;
      end
    end
  end

  // read pointer, kept relative to the oldest entry
  always_comb
  begin
    rd_idx_d = rd_idx_q;
    if (rd_num && cur_valid)
    begin
      rd_idx_d = rd_idx_q + 1'b1;
    end
    if (log_take && (fill_q == FULL_FILL) && (rd_idx_d != '0))
    begin
      rd_idx_d = rd_idx_d - 1'b1;
    end
    if (wr_rew || (wr_clr && !clearing))
    begin
      rd_idx_d = '0;
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      rd_idx_q <= '0;
    end
    else
    begin
      rd_idx_q <= rd_idx_d;
    end
  end

  // holding buffer, loaded only by an error number read
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      hold_q <= '0;
    end
    else if (rd_num)
    begin
      hold_q <= cur_entry;
    end
  end

  // power-on cycle count, saturating
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      power_on_q <= POWER_ON_RESET;
    end
    else if (POWER_ON_IN && (power_on_q != POWER_ON_MAX))
    begin
      power_on_q <= power_on_q + 1'b1;
    end
  end

  // enable cycles since supply on, and seconds since the last enable
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      enable_prev_q   <= 1'b0;
      enable_cycles_q <= ENABLE_COUNT_RESET;
      enable_time_q   <= ENABLE_TIME_RESET;
    end
    else
    begin
      enable_prev_q <= ENABLE_IN;
      if (enable_rise && (enable_cycles_q != COUNT16_MAX))
      begin
        enable_cycles_q <= enable_cycles_q + 1'b1;
      end
      if (enable_rise)
      begin
        enable_time_q <= ENABLE_TIME_RESET;
      end
      else if (ENABLE_IN && SEC_TICK_IN && (enable_time_q != COUNT16_MAX))
      begin
        enable_time_q <= enable_time_q + 1'b1;
      end
    end
  end

  // read answer, one cycle after the strobe
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      PAR_ACK_OUT   <= 1'b0;
      PAR_RDATA_OUT <= RDATA_RESET;
    end
    else
    begin
      PAR_ACK_OUT <= PAR_RD_IN;
      if (PAR_RD_IN)
      begin
        PAR_RDATA_OUT <= read_value(PAR_ADDR_IN, view_entry, clearing, power_on_q);
      end
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      CLEAR_BUSY_OUT <= 1'b0;
    end
    else
    begin
      CLEAR_BUSY_OUT <= (clr_state_q == CLR_IDLE) ? wr_clr : (clr_idx_q != LAST_SLOT);
    end
  end

endmodule : fault_history_memory

`default_nettype wire

// *** dv/fault_history_memory_chk.sv ***
// port checker for the fault history memory
`timescale 1ns/1ps
`default_nettype none
module fault_history_memory_chk #(
  parameter int ENTRY_DEPTH = 16
) (
  input wire logic        CLK_IN,         // clock
  input wire logic        RST_IN,         // sync reset
  input wire logic [15:0] PAR_ADDR_IN,    // address
  input wire logic        PAR_RD_IN,      // read strobe
  input wire logic        PAR_WR_IN,      // write strobe
  input wire logic [15:0] PAR_WDATA_IN,   // write data
  input wire logic [31:0] PAR_RDATA_OUT,  // read data
  input wire logic        PAR_ACK_OUT,    // read valid
  input wire logic        CLEAR_BUSY_OUT  // erasure running
);
  import fault_history_pkg::*;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);
  logic [31:0] busy_cnt_q;
  // consecutive busy cycles seen so far
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN || !CLEAR_BUSY_OUT)
      busy_cnt_q <= 32'h0000_0000;
    else
      busy_cnt_q <= busy_cnt_q + 32'h0000_0001;
  end
  ack_follows_rd_a: assert property (PAR_RD_IN |=> PAR_ACK_OUT)
    else $error("read without answer");
  ack_needs_rd_a: assert property (!PAR_RD_IN |=> !PAR_ACK_OUT)
    else $error("answer without read");
  data_held_a: assert property (!PAR_RD_IN |=> $stable(PAR_RDATA_OUT))
    else $error("read data moved without read");
  clear_starts_a: assert property (PAR_WR_IN && PAR_ADDR_IN == ADDR_CLEAR_HISTORY_COMMAND
    && PAR_WDATA_IN == CMD_EXECUTE && !CLEAR_BUSY_OUT |=> CLEAR_BUSY_OUT) else $error("clear not started");
  clear_length_a: assert property ($fell(CLEAR_BUSY_OUT) |-> busy_cnt_q == ENTRY_DEPTH)
    else $error("erasure length wrong");
  clear_status_a: assert property (PAR_RD_IN && PAR_ADDR_IN == ADDR_CLEAR_HISTORY_COMMAND
    |=> PAR_RDATA_OUT == 32'($past(CLEAR_BUSY_OUT))) else $error("clear status wrong");
  rewind_zero_a: assert property (PAR_RD_IN && PAR_ADDR_IN == ADDR_REWIND_READ_POINTER
    |=> PAR_RDATA_OUT == 32'h0000_0000) else $error("rewind reads nonzero");
  severity_range_a: assert property (PAR_RD_IN && PAR_ADDR_IN == ADDR_ENTRY_SEVERITY
    |=> PAR_RDATA_OUT <= 32'h0000_0004) else $error("severity out of range");
  time_limit_a: assert property (PAR_RD_IN && PAR_ADDR_IN == ADDR_ENTRY_TIMESTAMP
    |=> PAR_RDATA_OUT <= TIMESTAMP_MAX) else $error("timestamp above limit");
  clear_c: cover property ($fell(CLEAR_BUSY_OUT));
  entry_c: cover property (PAR_RD_IN && PAR_ADDR_IN == ADDR_ENTRY_ERROR_NUMBER);
  rewind_c: cover property (PAR_WR_IN && PAR_ADDR_IN == ADDR_REWIND_READ_POINTER);
endmodule : fault_history_memory_chk
bind fault_history_memory fault_history_memory_chk #(.ENTRY_DEPTH(ENTRY_DEPTH)) u_chk (.CLK_IN, .RST_IN,
  .PAR_ADDR_IN, .PAR_RD_IN, .PAR_WR_IN, .PAR_WDATA_IN, .PAR_RDATA_OUT, .PAR_ACK_OUT, .CLEAR_BUSY_OUT);
`default_nettype wire

// *** dv/fieldbus_master.sv ***
// fieldbus master model for parameter access
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master (
  input  wire logic        clk_in,   // clock
  input  wire logic        ack_in,   // read valid
  input  wire logic [31:0] rdata_in, // read data
  output logic      [15:0] addr_out, // address
  output logic             rd_out,   // read strobe
  output logic             wr_out,   // write strobe
  output logic      [15:0] wdata_out // write data
);
  initial {addr_out, rd_out, wr_out, wdata_out} = '0;
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output bit late);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;
    @(posedge clk_in);
    late = !ack_in;
    d    = rdata_in;
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= v;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    addr_out  <= ~a;
    wdata_out <= ~v;
  endtask : wr
  // completion is only known by reading zero back
  task automatic poll_clear(output int n, output bit late);
    logic [31:0] d;
    n    = 0;
    late = 1'b0;
    d    = 32'h0000_0001;
    while (d !== 32'h0000_0000 && !late && n < 40)
    begin
      rd(16'h3b08, d, late);
      n++;
    end
  endtask : poll_clear
endmodule : fieldbus_master
`default_nettype wire

// *** dv/tb_fault_history_memory.sv ***
// self-checking bench for the fault history memory
`timescale 1ns/1ps
`default_nettype none
module tb_fault_history_memory;
  import fault_history_pkg::*;
  localparam int   DEPTH = 4;
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic            pwr = 1'b0;
  logic            ena = 1'b0;
  logic            tick = 1'b0;
  logic [31:0]     secs = '0;
  logic            logv = 1'b0;
  fault_event_type ev = '0;
  logic [15:0]     addr;
  logic            rd;
  logic            wr;
  logic [15:0]     wd;
  logic [31:0]     rdata;
  logic            ack;
  logic            busy;
  int              error_cnt = 0;
  int              samples_checked = 0;
  int              ptr = 0;
  logic [15:0]     cyc = '0;
  logic [15:0]     tim = '0;
  logic [2:0]      sev = '0;
  entry_type       hist[$];
  entry_type       hold;
  always #2 clk = ~clk;
  fault_history_memory #(.ENTRY_DEPTH(DEPTH)) DUT (.CLK_IN(clk), .RST_IN(rst), .POWER_ON_IN(pwr),
    .ENABLE_IN(ena), .SEC_TICK_IN(tick), .OP_SECONDS_IN(secs), .LOG_VALID_IN(logv), .LOG_EVENT_IN(ev),
    .PAR_ADDR_IN(addr), .PAR_RD_IN(rd), .PAR_WR_IN(wr), .PAR_WDATA_IN(wd), .PAR_RDATA_OUT(rdata),
    .PAR_ACK_OUT(ack), .CLEAR_BUSY_OUT(busy));
  fieldbus_master u_mst (.clk_in(clk), .ack_in(ack), .rdata_in(rdata), .addr_out(addr), .rd_out(rd),
    .wr_out(wr), .wdata_out(wd));
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rc(logic [15:0] a, logic [31:0] exp, string nm);
    logic [31:0] d;
    bit          late;
    u_mst.rd(a, d, late);
    if (late)
    begin
      error_cnt++;
      conclude();
    end
    else
      chk(nm, d, exp);
  endtask : rc
  function automatic logic [31:0] fld(entry_type e, int i);
    logic [31:0] x [10];
    x = '{32'(e.severity), e.timestamp, 32'(e.extra_info), 32'(e.enable_cycles),
      32'(e.time_after_enable), 32'(e.bus_voltage), {16'h0000, e.motor_speed},
      32'(e.motor_current), {16'h0000, e.power_stage_temp}, {16'h0000, e.device_temp}};
    return x[i];
  endfunction : fld
  task automatic rd_all(int n);
    repeat (n)
    begin
      hold = '0;
      if (ptr < hist.size())
        hold = hist[ptr++];
      rc(16'h3c02, 32'(hold.err_num), "err_num");
      for (int i = 0; i < 10; i++)
        rc(16'h3c04 + 16'(2 * i), fld(hold, i), "field");
      rc(16'h3c04, fld(hold, 0), "field_again");
    end
  endtask : rd_all
  task automatic pulse(int k);
    if (k == 1 && ena)
      tim++;
    if (k == 2 && !ena)
    begin
      cyc++;
      tim = '0;
    end
    @(posedge clk);
    case (k)
      0: pwr <= 1'b1;
      1: tick <= 1'b1;
      default: ena <= ~ena;
    endcase
    @(posedge clk);
    {pwr, tick} <= 2'b00;
  endtask : pulse
  task automatic log_one(logic [31:0] s);
    logic [127:0]    r;
    fault_event_type v;
    entry_type       e;
    r = {$urandom, $urandom, $urandom, $urandom};
    v = r[$bits(v)-1:0];
    v.err_num = 16'($urandom_range(65535, 1));
    v.severity = sev++;
    e = '{v.err_num, severity_type'(v.severity > 3'h4 ? 3'h4 : v.severity), s > TIMESTAMP_MAX ?
      TIMESTAMP_MAX : s, v.extra_info, cyc, tim, v.bus_voltage, v.motor_speed, v.motor_current,
      v.power_stage_temp, v.device_temp};
    @(posedge clk);
    logv <= 1'b1;
    ev   <= v;
    secs <= s;
    @(posedge clk);
    logv <= 1'b0;
    if (hist.size() == DEPTH)
    begin
      void'(hist.pop_front());
      if (ptr > 0)
        ptr--;
    end
    hist.push_back(e);
  endtask : log_one
  initial
  begin
    int seq[6];
    int n;
    bit late;
    seq = '{2, 1, 2, 2, 1, 1};
    n = $urandom(32'h40d6);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rc(16'h3b04, 32'h0000_0000, "power_on");
    rc(16'h3b08, 32'h0000_0000, "clear_cmd");
    rc(16'h3b0a, 32'h0000_0000, "rewind_cmd");
    rc(16'h3c00, 32'h0000_0000, "unmapped");
    rd_all(1);
    $display("test reset done");
    repeat (3) pulse(0);
    u_mst.wr(16'h3b04, 16'h0005);
    rc(16'h3b04, 32'h0000_0003, "power_on");
    foreach (seq[i]) pulse(seq[i]);
    log_one($urandom % 1000);
    log_one(32'hffff_ffff);
    log_one(32'h1fff_ffff);
    rd_all(DEPTH);
    $display("test read done");
    u_mst.wr(16'h3b0a, 16'h0002);
    rd_all(1);
    u_mst.wr(16'h3b0a, 16'h0001);
    ptr = 0;
    rd_all(1);
    repeat (4) log_one($urandom % 1000);
    rd_all(1);
    u_mst.wr(16'h3b0a, 16'h0001);
    ptr = 0;
    rd_all(DEPTH + 1);
    $display("test overflow done");
    u_mst.wr(16'h3b08, 16'h0001);
    hist.delete();
    ptr = 0;
    u_mst.poll_clear(n, late);
    // a poll that ran out of its bound ends the run as a failure
    if (late || n >= 40)
    begin
      error_cnt++;
      conclude();
    end
    chk("clear_polls", 32'(n > 1 && n < 40 && !late), 32'h0000_0001);
    rd_all(1);
    log_one(32'h0000_0007);
    rd_all(1);
    $display("test clear done");
    conclude();
  end
endmodule : tb_fault_history_memory
`default_nettype wire
